// ==== src/pps_top.sv ====
/*
  Sixteen-channel pulse sequencer with AXI4-Lite register access, sticky completion status,
  interrupt and pin sharing with two GPIO groups.
  Assumes one 200 MHz clock, synchronous active-high reset and pin inputs synchronous to the clock.
*/
// Operation
// - Pulse timing steps at 50 MHz, 20 ns resolution.
// - Once started, pulses run in hardware without processor action.
// - Counting mode emits exactly the programmed pulses, then stops.
// - Continuous mode repeats until software reconfigures or stops it.
// - After a counted end, a new sequence is accepted without reset.
// - Enabled completion raises the interrupt request.
// - Completion sets a readable status flag for polling.
// - Control register reports pulses remaining.
// - Output groups 0 and 1 share pins with GPIO groups 0 and 1.
// - Two groups of eight channels, sixteen outputs.
`timescale 1ns/1ps
module pps_top (
  input wire logic ref_clk, // System clock, 200 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic [pps_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [pps_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [pps_pkg::NCH-1:0] pin_i, // Shared pin levels
  output logic [pps_pkg::NCH-1:0] pin_o, // Shared pin drive value
  output logic [pps_pkg::NCH-1:0] pin_oe, // Shared pin drive enable
  output logic irq // Level interrupt
);
  localparam int NCH = pps_pkg::NCH;

  // Bus handshake state
  logic awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
  logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt, wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [pps_pkg::ADDR_W-1:0] awaddr_r, awaddr_nxt;

  // Register state
  logic [NCH-1:0] status_r, status_nxt, irq_en_r, irq_en_nxt;
  logic [pps_pkg::NGRP-1:0] pin_sel_r, pin_sel_nxt;
  logic [NCH-1:0] gpio_out_r, gpio_out_nxt, gpio_oe_r, gpio_oe_nxt;
  logic [NCH-1:0] cont_r, cont_nxt, start_r, start_nxt, stop_r, stop_nxt;
  logic [pps_pkg::LEN_W-1:0] high_r [NCH], high_nxt [NCH];
  logic [pps_pkg::LEN_W-1:0] low_r [NCH], low_nxt [NCH];
  logic [pps_pkg::CNT_W-1:0] cnt_r [NCH], cnt_nxt [NCH];
  logic irq_r, irq_nxt;
  logic [NCH-1:0] pin_o_r, pin_o_nxt, pin_oe_r, pin_oe_nxt;

  // Counter step divider
  logic [pps_pkg::TDIV_W-1:0] div_r, div_nxt;
  logic tick_r, tick_nxt;

  // Channel outputs
  logic [NCH-1:0] pwm, busy, done;
  logic [pps_pkg::CNT_W-1:0] remain [NCH];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  always_comb begin
    tick_nxt = (div_r == pps_pkg::TDIV_LAST);
    div_nxt = tick_nxt ? '0 : div_r + 3'h1;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      pps_chan u_chan (
        .ref_clk(ref_clk),
        .srst(srst),
        .tick(tick_r),
        .start(start_r[gi]),
        .stop(stop_r[gi]),
        .cont(cont_r[gi]),
        .high_len(high_r[gi]),
        .low_len(low_r[gi]),
        .count(cnt_r[gi]),
        .pwm(pwm[gi]),
        .busy(busy[gi]),
        .remain(remain[gi]),
        .done(done[gi])
      );
    end
  endgenerate

  // Write path, register effects and read path
  always_comb begin
    logic [31:0] wv;
    logic [3:0] ch;
    logic [31:0] old;
    logic hit;
    wv = '0;
    ch = '0;
    old = '0;
    hit = 1'b0;
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    status_nxt = status_r | done;
    irq_en_nxt = irq_en_r;
    pin_sel_nxt = pin_sel_r;
    gpio_out_nxt = gpio_out_r;
    gpio_oe_nxt = gpio_oe_r;
    cont_nxt = cont_r;
    start_nxt = '0;
    stop_nxt = '0;
    high_nxt = high_r;
    low_nxt = low_r;
    cnt_nxt = cnt_r;

    if (s_axi_awvalid && awready_r) begin
      awaddr_nxt = s_axi_awaddr;
      awready_nxt = 1'b0;
    end
    if (s_axi_wvalid && wready_r) begin
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
      wready_nxt = 1'b0;
    end
    if (bvalid_r) begin
      if (s_axi_bready) begin
        bvalid_nxt = 1'b0;
        awready_nxt = 1'b1;
        wready_nxt = 1'b1;
      end
    end else if (!awready_r && !wready_r) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = pps_pkg::RESP_OKAY;
      ch = awaddr_r[7:4];
      if (awaddr_r[11:8] == pps_pkg::CH_REGION && awaddr_r[3:2] != 2'h3) begin
        unique case (awaddr_r[3:2])
          pps_pkg::CH_CTRL: begin
            old = {cnt_r[ch], 14'h0000, cont_r[ch], 1'b0};
            wv = merge(old, wdata_r, wstrb_r);
            cont_nxt[ch] = wv[pps_pkg::CTRL_CONT_BIT];
            cnt_nxt[ch] = wv[pps_pkg::CTRL_CNT_LSB +: pps_pkg::CNT_W];
            if (wstrb_r[0]) begin
              start_nxt[ch] = wv[pps_pkg::CTRL_RUN_BIT];
              stop_nxt[ch] = !wv[pps_pkg::CTRL_RUN_BIT];
            end
          end
          pps_pkg::CH_HIGH: begin
            wv = merge({16'h0000, high_r[ch]}, wdata_r, wstrb_r);
            high_nxt[ch] = wv[pps_pkg::LEN_W-1:0];
          end
          pps_pkg::CH_LOW: begin
            wv = merge({16'h0000, low_r[ch]}, wdata_r, wstrb_r);
            low_nxt[ch] = wv[pps_pkg::LEN_W-1:0];
          end
          default: begin
          end
        endcase
      end else begin
        unique case (awaddr_r)
          pps_pkg::OFS_CLEAR: begin
            wv = merge('0, wdata_r, wstrb_r);
            status_nxt = (status_r & ~wv[NCH-1:0]) | done;
          end
          pps_pkg::OFS_IRQ_EN: begin
            wv = merge({16'h0000, irq_en_r}, wdata_r, wstrb_r);
            irq_en_nxt = wv[NCH-1:0];
          end
          pps_pkg::OFS_PIN_SEL: begin
            wv = merge({30'h00000000, pin_sel_r}, wdata_r, wstrb_r);
            pin_sel_nxt = wv[pps_pkg::NGRP-1:0];
          end
          pps_pkg::OFS_GPIO_OUT: begin
            wv = merge({16'h0000, gpio_out_r}, wdata_r, wstrb_r);
            gpio_out_nxt = wv[NCH-1:0];
          end
          pps_pkg::OFS_GPIO_OE: begin
            wv = merge({16'h0000, gpio_oe_r}, wdata_r, wstrb_r);
            gpio_oe_nxt = wv[NCH-1:0];
          end
          pps_pkg::OFS_STATUS, pps_pkg::OFS_GPIO_IN: begin
          end
          default: bresp_nxt = pps_pkg::RESP_SLVERR;
        endcase
      end
    end

    if (rvalid_r) begin
      if (s_axi_rready) begin
        rvalid_nxt = 1'b0;
        arready_nxt = 1'b1;
      end
    end else if (s_axi_arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = pps_pkg::RESP_OKAY;
      rdata_nxt = '0;
      ch = s_axi_araddr[7:4];
      hit = 1'b1;
      if (s_axi_araddr[11:8] == pps_pkg::CH_REGION && s_axi_araddr[3:2] != 2'h3) begin
        unique case (s_axi_araddr[3:2])
          pps_pkg::CH_CTRL: rdata_nxt = {remain[ch], 14'h0000, cont_r[ch], busy[ch]};
          pps_pkg::CH_HIGH: rdata_nxt = {16'h0000, high_r[ch]};
          pps_pkg::CH_LOW: rdata_nxt = {16'h0000, low_r[ch]};
          default: hit = 1'b0;
        endcase
      end else begin
        unique case (s_axi_araddr)
          pps_pkg::OFS_STATUS: rdata_nxt = {16'h0000, status_r};
          pps_pkg::OFS_CLEAR: rdata_nxt = '0;
          pps_pkg::OFS_IRQ_EN: rdata_nxt = {16'h0000, irq_en_r};
          pps_pkg::OFS_PIN_SEL: rdata_nxt = {30'h00000000, pin_sel_r};
          pps_pkg::OFS_GPIO_OUT: rdata_nxt = {16'h0000, gpio_out_r};
          pps_pkg::OFS_GPIO_OE: rdata_nxt = {16'h0000, gpio_oe_r};
          pps_pkg::OFS_GPIO_IN: rdata_nxt = {16'h0000, pin_i};
          default: hit = 1'b0;
        endcase
      end
      if (!hit) begin
        rresp_nxt = pps_pkg::RESP_SLVERR;
      end
    end

    irq_nxt = |(status_nxt & irq_en_nxt);
    for (int i = 0; i < NCH; i++) begin
      pin_o_nxt[i] = pin_sel_r[i / pps_pkg::GRP_SIZE] ? pwm[i] : gpio_out_r[i];
      pin_oe_nxt[i] = pin_sel_r[i / pps_pkg::GRP_SIZE] | gpio_oe_r[i];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= pps_pkg::RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= pps_pkg::RESP_OKAY;
      rdata_r <= '0;
      status_r <= pps_pkg::STATUS_RST;
      irq_en_r <= pps_pkg::IRQ_EN_RST;
      pin_sel_r <= pps_pkg::PIN_SEL_RST;
      gpio_out_r <= '0;
      gpio_oe_r <= '0;
      cont_r <= '0;
      start_r <= '0;
      stop_r <= '0;
      for (int i = 0; i < NCH; i++) begin
        high_r[i] <= pps_pkg::LEN_RST;
        low_r[i] <= pps_pkg::LEN_RST;
        cnt_r[i] <= '0;
      end
      irq_r <= 1'b0;
      pin_o_r <= '0;
      pin_oe_r <= '0;
      div_r <= '0;
      tick_r <= 1'b0;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      status_r <= status_nxt;
      irq_en_r <= irq_en_nxt;
      pin_sel_r <= pin_sel_nxt;
      gpio_out_r <= gpio_out_nxt;
      gpio_oe_r <= gpio_oe_nxt;
      cont_r <= cont_nxt;
      start_r <= start_nxt;
      stop_r <= stop_nxt;
      high_r <= high_nxt;
      low_r <= low_nxt;
      cnt_r <= cnt_nxt;
      irq_r <= irq_nxt;
      pin_o_r <= pin_o_nxt;
      pin_oe_r <= pin_oe_nxt;
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign irq = irq_r;
  assign pin_o = pin_o_r;
  assign pin_oe = pin_oe_r;

  tick_spacing_a: assert property (@(posedge ref_clk) disable iff (srst) tick_r |=> !tick_r [*3] ##1 tick_r)
    else $error("counter step not every four cycles");
  done_sets_flag_a: assert property (@(posedge ref_clk) disable iff (srst) (done != '0) |=> ((status_r & $past(done)) == $past(done)))
    else $error("completion did not set status");
  flag_sticky_a: assert property (@(posedge ref_clk) disable iff (srst)
    (status_r[0] && !(bvalid_nxt && !bvalid_r && awaddr_r == pps_pkg::OFS_CLEAR)) |=> status_r[0])
    else $error("status flag lost without a clear");
  irq_follows_a: assert property (@(posedge ref_clk) disable iff (srst)
    irq == |(status_r & irq_en_r))
    else $error("interrupt does not track enabled status");
  irq_clear_drop_a: assert property (@(posedge ref_clk) disable iff (srst)
    (status_nxt == '0) |=> !irq)
    else $error("interrupt held after all flags cleared");
  restart_ok_a: assert property (@(posedge ref_clk) disable iff (srst)
    (start_r[0] && !stop_r[0] && (cont_r[0] || cnt_r[0] != '0)) |=> busy[0])
    else $error("new sequence refused after completion");
  pin_share_a: assert property (@(posedge ref_clk) disable iff (srst)
    (pin_sel_r[1] && $stable(pin_sel_r)) |=> (pin_o[8] == $past(pwm[8])) && pin_oe[8])
    else $error("pin not routed to pulse output");
  write_resp_c: cover property (@(posedge ref_clk) disable iff (srst) bvalid_r && s_axi_bready);
  irq_raise_c: cover property (@(posedge ref_clk) disable iff (srst) $rose(irq));
  unmapped_c: cover property (@(posedge ref_clk) disable iff (srst) rvalid_r && rresp_r == pps_pkg::RESP_SLVERR);
endmodule // pps_top

// ==== src/pps_pkg.sv ====
/*
  Shared constants for the pulse sequencer: timing, widths, register map and field layout.
  Assumes a single 200 MHz system clock; the 50 MHz counter rate is derived as an enable.
*/
package pps_pkg;
  localparam int CLK_MHZ = 200;
  localparam int STEP_NS = 20;
  // Counter step in system cycles, rounded down but never below one
  localparam int TICK_DIV = (STEP_NS * CLK_MHZ / 1000) < 1 ? 1 : (STEP_NS * CLK_MHZ / 1000);
  localparam int TDIV_W = 3;
  localparam logic [TDIV_W-1:0] TDIV_LAST = 3'(TICK_DIV - 1);

  localparam int NCH = 16;
  localparam int GRP_SIZE = 8;
  localparam int NGRP = 2;
  localparam int LEN_W = 16;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 12;

  // Global registers
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CLEAR = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_PIN_SEL = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_GPIO_OUT = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_GPIO_OE = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_GPIO_IN = 12'h018;
  // Channel block: base + ch * stride, three words each
  localparam logic [3:0] CH_REGION = 4'h1;
  localparam logic [1:0] CH_CTRL = 2'h0;
  localparam logic [1:0] CH_HIGH = 2'h1;
  localparam logic [1:0] CH_LOW = 2'h2;

  // Channel control fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_CONT_BIT = 1;
  localparam int CTRL_CNT_LSB = 16;

  localparam logic [NCH-1:0] STATUS_RST = 16'h0000;
  localparam logic [NCH-1:0] IRQ_EN_RST = 16'h0000;
  localparam logic [NGRP-1:0] PIN_SEL_RST = 2'h0;
  localparam logic [LEN_W-1:0] LEN_RST = 16'h0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_HIGH, ST_LOW} pps_st_e;
endpackage

// ==== src/pps_chan.sv ====
/*
  One pulse channel: high phase, low phase, repeated a counted number of times or forever.
  Assumes tick is a one-cycle enable at the counter rate and start/stop are one-cycle pulses.
*/
`timescale 1ns/1ps
module pps_chan (
  input wire logic ref_clk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic tick, // Counter step enable
  input wire logic start, // Load count and begin
  input wire logic stop, // Abort sequence
  input wire logic cont, // Continuous mode
  input wire logic [pps_pkg::LEN_W-1:0] high_len, // High steps
  input wire logic [pps_pkg::LEN_W-1:0] low_len, // Low steps
  input wire logic [pps_pkg::CNT_W-1:0] count, // Pulses to emit
  output logic pwm, // Pulse output
  output logic busy, // Sequence running
  output logic [pps_pkg::CNT_W-1:0] remain, // Pulses still pending
  output logic done // End of counted sequence
);
  pps_pkg::pps_st_e st_r, st_nxt;
  logic [pps_pkg::LEN_W-1:0] tmr_r, tmr_nxt;
  logic [pps_pkg::CNT_W-1:0] rem_r, rem_nxt;
  logic done_r, done_nxt;
  logic pwm_r;

  always_comb begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    rem_nxt = rem_r;
    done_nxt = 1'b0;
    if (stop) begin
      st_nxt = pps_pkg::ST_IDLE;
    end else if (start) begin
      st_nxt = pps_pkg::ST_HIGH;
      tmr_nxt = high_len;
      rem_nxt = count;
      if (!cont && count == '0) begin
        st_nxt = pps_pkg::ST_IDLE;
        done_nxt = 1'b1;
      end
    end else if (tick) begin
      unique case (st_r)
        pps_pkg::ST_IDLE: begin
        end
        pps_pkg::ST_HIGH: begin
          if (tmr_r <= 16'h0001) begin
            st_nxt = pps_pkg::ST_LOW;
            tmr_nxt = low_len;
          end else begin
            tmr_nxt = tmr_r - 16'h0001;
          end
        end
        pps_pkg::ST_LOW: begin
          if (tmr_r > 16'h0001) begin
            tmr_nxt = tmr_r - 16'h0001;
          end else if (cont) begin
            st_nxt = pps_pkg::ST_HIGH;
            tmr_nxt = high_len;
          end else if (rem_r <= 16'h0001) begin
            st_nxt = pps_pkg::ST_IDLE;
            rem_nxt = '0;
            done_nxt = 1'b1;
          end else begin
            rem_nxt = rem_r - 16'h0001;
            st_nxt = pps_pkg::ST_HIGH;
            tmr_nxt = high_len;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r <= pps_pkg::ST_IDLE;
      tmr_r <= '0;
      rem_r <= '0;
      done_r <= 1'b0;
      pwm_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      rem_r <= rem_nxt;
      done_r <= done_nxt;
      pwm_r <= (st_nxt == pps_pkg::ST_HIGH);
    end
  end

  assign pwm = pwm_r;
  assign busy = (st_r != pps_pkg::ST_IDLE);
  assign remain = rem_r;
  assign done = done_r;

  done_goes_idle_a: assert property (@(posedge ref_clk) disable iff (srst) done |-> !busy)
    else $error("done without returning to idle");
  cont_never_ends_a: assert property (@(posedge ref_clk) disable iff (srst)
    (busy && cont && !start && !stop) |=> !done)
    else $error("continuous run ended by itself");
  rem_step_a: assert property (@(posedge ref_clk) disable iff (srst)
    (st_r == pps_pkg::ST_LOW && tick && tmr_r == 16'h0001 && !cont && rem_r > 16'h0001 && !start && !stop)
    |=> (rem_r == $past(rem_r) - 16'h0001) && pwm)
    else $error("remaining count not stepped at pulse end");
  no_tick_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    (!tick && !start && !stop) |=> $stable(st_r) && $stable(tmr_r))
    else $error("channel moved without a counter step");
  start_runs_a: assert property (@(posedge ref_clk) disable iff (srst)
    (start && !stop && (cont || count != '0)) |=> pwm && busy)
    else $error("start did not raise the output");
  counted_run_c: cover property (@(posedge ref_clk) disable iff (srst) busy && !cont ##[1:200] done);
  cont_run_c: cover property (@(posedge ref_clk) disable iff (srst)
    cont && st_r == pps_pkg::ST_LOW && tick && tmr_r == 16'h0001);
endmodule // pps_chan

// ==== verification/pps_load_model.sv ====
/*
  Load on the sixteen shared pins: power switches plus an outside driver for GPIO input checks.
  Assumes pins are sampled on the system clock; an undriven pin floats to its pull-up.
*/
`timescale 1ns/1ps
module pps_load_model (
  input wire logic ref_clk, // System clock
  input wire logic [pps_pkg::NCH-1:0] pin_o, // Drive value from the block
  input wire logic [pps_pkg::NCH-1:0] pin_oe, // Drive enable from the block
  input wire logic [pps_pkg::NCH-1:0] ext_val, // Outside level
  input wire logic [pps_pkg::NCH-1:0] ext_en, // Outside drive enable
  output logic [pps_pkg::NCH-1:0] pin_i // Resolved pin level
);
  int rises [pps_pkg::NCH] = '{default: 0};
  int last_high [pps_pkg::NCH] = '{default: 0};
  int run [pps_pkg::NCH] = '{default: 0};
  logic [pps_pkg::NCH-1:0] prev = '0;
  // Pull-up wins only when nobody drives
  always_comb pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
  // Switches only see pulses while the block drives the pin
  always @(posedge ref_clk) begin
    for (int i = 0; i < pps_pkg::NCH; i++) begin
      if (pin_oe[i] && pin_i[i] && !prev[i]) begin
        rises[i]++;
        run[i] = 1;
      end else if (pin_oe[i] && pin_i[i]) begin
        run[i]++;
      end else if (prev[i]) begin
        last_high[i] = run[i];
      end
    end
    prev <= pin_i & pin_oe;
  end
endmodule // pps_load_model

// ==== verification/pwm_pulse_sequencer_tb_top.sv ====
/*
  Self-checking bench for the pulse sequencer: register bus, counted and continuous runs, pin sharing.
  Assumes the load model on the pins and read results checked from a queue of expected notes.
*/
`timescale 1ns/1ps
module pwm_pulse_sequencer_tb_top;
  typedef struct packed {logic [31:0] v; logic [31:0] m; logic [1:0] r;} pps_rexp_s;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [pps_pkg::ADDR_W-1:0] s_axi_awaddr = '0;
  logic [pps_pkg::ADDR_W-1:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] pin_i, pin_o, pin_oe;
  logic [15:0] ext_val = '0;
  logic [15:0] ext_en = '0;
  logic [31:0] seed = 32'h0000cfa0;
  logic [31:0] d, r;
  int failures = 0;
  int check_count = 0;
  int base;
  pps_rexp_s exp_r [$];
  logic [1:0] exp_b [$];

  always #2.5 ref_clk = ~ref_clk;

  pps_top pps_top_inst (.ref_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_i,
    .pin_o, .pin_oe, .irq);
  pps_load_model pps_load_model_inst (.ref_clk, .pin_o, .pin_oe, .ext_val, .ext_en, .pin_i);

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [11:0] ca(input logic [3:0] ch, input logic [1:0] w);
    return {pps_pkg::CH_REGION, ch, w, 2'h0};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Results arrive in request order, so the oldest note belongs to this answer
  always @(posedge ref_clk) begin
    if (s_axi_rvalid && s_axi_rready) begin : rmon
      pps_rexp_s e;
      e = exp_r.pop_front();
      chk("rdata", s_axi_rdata & e.m, e.v & e.m);
      chk("rresp", 32'(s_axi_rresp), 32'(e.r));
    end
    if (s_axi_bvalid && s_axi_bready) chk("bresp", 32'(s_axi_bresp), 32'(exp_b.pop_front()));
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] rs = pps_pkg::RESP_OKAY);
    exp_b.push_back(rs);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // No cycle budget here: only the watchdog ends a stuck wait
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic [31:0] m = '1,
                    input logic [1:0] rs = pps_pkg::RESP_OKAY);
    exp_r.push_back('{v, m, rs});
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask

  task automatic run_cnt(input logic [3:0] ch, input logic [15:0] cnt, h, l, input logic en);
    logic [15:0] bm;
    bm = 16'h1 << ch;
    base = pps_load_model_inst.rises[ch];
    wr(ca(ch, pps_pkg::CH_HIGH), {16'h0, h});
    wr(ca(ch, pps_pkg::CH_LOW), {16'h0, l});
    wr(pps_pkg::OFS_IRQ_EN, {16'h0, en ? bm : 16'h0});
    wr(ca(ch, pps_pkg::CH_CTRL), {cnt, 16'h1});
    rd(ca(ch, pps_pkg::CH_CTRL), {cnt, 16'h1});
    for (int n = 0; n < 400; n++) begin
      rd(pps_pkg::OFS_STATUS, 32'h0, 32'h0);
      if (d[ch]) break;
    end
    chk("pulses", 32'(pps_load_model_inst.rises[ch] - base), 32'(cnt));
    chk("high width", 32'(pps_load_model_inst.last_high[ch]), 32'(h) * 32'h4);
    repeat (2) @(posedge ref_clk);
    chk("irq", 32'(irq), 32'(en));
    rd(pps_pkg::OFS_STATUS, {16'h0, bm});
    rd(ca(ch, pps_pkg::CH_CTRL), 32'h0);
    wr(pps_pkg::OFS_CLEAR, {16'h0, bm});
    rd(pps_pkg::OFS_STATUS, 32'h0);
    chk("irq cleared", 32'(irq), 32'h0);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    rd(pps_pkg::OFS_STATUS, 32'h0);
    rd(pps_pkg::OFS_IRQ_EN, 32'h0);
    rd(pps_pkg::OFS_PIN_SEL, 32'h0);
    rd(ca(4'h0, pps_pkg::CH_HIGH), 32'h1);
    rd(ca(4'h0, pps_pkg::CH_CTRL), 32'h0);
    chk("pin_oe reset", 32'(pin_oe), 32'h0);
    wr(pps_pkg::OFS_STATUS, 32'hffffffff);
    rd(pps_pkg::OFS_STATUS, 32'h0);
    wr(12'h01c, 32'hffffffff, pps_pkg::RESP_SLVERR);
    rd(12'h01c, 32'h0, 32'hffffffff, pps_pkg::RESP_SLVERR);
    rd(ca(4'h0, 2'h3), 32'h0, 32'hffffffff, pps_pkg::RESP_SLVERR);
    // Counted start with a zero count ends at once, with no pulse
    wr(ca(4'h3, pps_pkg::CH_CTRL), 32'h00000001);
    rd(pps_pkg::OFS_STATUS, 32'h8);
    wr(pps_pkg::OFS_CLEAR, 32'h8);
    rd(pps_pkg::OFS_STATUS, 32'h0);
    $display("test registers done");
    wr(pps_pkg::OFS_PIN_SEL, 32'h3);
    run_cnt(4'h0, 16'h5, 16'h2, 16'h3, 1'b1);
    run_cnt(4'h0, 16'h2, 16'h1, 16'h1, 1'b1);
    // Start is not aligned to a counter step, so the first pulse may be short; width is judged on a later one
    run_cnt(4'hf, 16'h2, 16'h1, 16'h2, 1'b0);
    for (int i = 0; i < 4; i++) begin
      r = xs();
      run_cnt(r[3:0], {14'h0, r[5:4]} + 16'h2, {14'h0, r[7:6]} + 16'h1, {14'h0, r[9:8]} + 16'h1, r[10]);
    end
    $display("test counted done");
    base = pps_load_model_inst.rises[9];
    wr(ca(4'h9, pps_pkg::CH_HIGH), 32'h1);
    wr(ca(4'h9, pps_pkg::CH_LOW), 32'h1);
    wr(ca(4'h9, pps_pkg::CH_CTRL), 32'h00010003);
    repeat (400) @(posedge ref_clk);
    chk("free run", 32'(pps_load_model_inst.rises[9] - base > 40), 32'h1);
    rd(pps_pkg::OFS_STATUS, 32'h0);
    rd(ca(4'h9, pps_pkg::CH_CTRL), 32'h3, 32'h3);
    wr(ca(4'h9, pps_pkg::CH_CTRL), 32'h0);
    repeat (10) @(posedge ref_clk);
    base = pps_load_model_inst.rises[9];
    repeat (40) @(posedge ref_clk);
    chk("stopped", 32'(pps_load_model_inst.rises[9] - base), 32'h0);
    chk("stopped pin", 32'(pin_o[9]), 32'h0);
    $display("test continuous done");
    wr(pps_pkg::OFS_PIN_SEL, 32'h0);
    wr(pps_pkg::OFS_GPIO_OE, 32'h000f);
    wr(pps_pkg::OFS_GPIO_OUT, 32'h00a5);
    ext_val <= 16'h3c00;
    ext_en <= 16'hff00;
    repeat (2) @(posedge ref_clk);
    chk("gpio oe", 32'(pin_oe), 32'h000f);
    chk("gpio out", 32'(pin_o & 16'h000f), 32'h0005);
    rd(pps_pkg::OFS_GPIO_IN, 32'h3cf5);
    wr(pps_pkg::OFS_PIN_SEL, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk("group1 oe", 32'(pin_oe), 32'hff0f);
    $display("test pins done");
    close_out();
  end

  initial begin
    #(5 * 40000);
    failures++;
    close_out();
  end
endmodule // pwm_pulse_sequencer_tb_top
